//--- logic/level_sync.sv
`timescale 1ns/100ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_s;

  sync_s state_reg;
  sync_s state_next;

  // First stage feeds only the second stage
  always_comb begin
    state_next = state_reg;
    state_next.first = async_in;
    state_next.second = state_reg.first;
  end

  // No reset: a synchroniser settles within two edges anyway
  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  assign sync_out = state_reg.second;
endmodule : level_sync

//--- logic/parallel_rgb_to_lvds_serializer.sv
// What this block does
// - Accept 18 colour bits plus line sync, frame sync and data valid.
// - Capture the parallel inputs on the falling edge of the shift clock.
// - Drive three serial lanes, each as a positive and negative leg.
// - Forward the clock on a fourth pair alongside the data lanes.
// - With power-down low, output_enable is deasserted; no output is put in high impedance.
// - Power-down resets the block, drops lock and holds it in standby.
// - Clock and data may first arrive after power-down is released.
// - Stopped then restarted clock relocks without cycling power-down.
// - Track spread-spectrum input clocks up to 100 kHz modulation.
// - Each lane carries seven slots, 0 to 6, per input clock period.
// - Lock is reached after 10 ms of a stable clock after release.
// - Outputs are disabled within 100 ns of power-down assertion.
`timescale 1ns/100ps
module parallel_rgb_to_lvds_serializer #(
  parameter int LOCK_CYCLES = serializer_pkg::LOCK_CYCLES,
  parameter int LOSS_CYCLES = serializer_pkg::LOSS_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic shift_clock_in,
  input wire logic [17:0] parallel_pixel_inputs,
  input wire logic line_sync,
  input wire logic frame_sync,
  input wire logic pixel_data_valid,
  input wire logic power_down_n,
  output logic [20:0] serial_lane_pos,
  output logic [20:0] serial_lane_neg,
  output logic [6:0] forwarded_clock_pos,
  output logic [6:0] forwarded_clock_neg,
  output logic output_enable,
  output logic pll_locked
);
  localparam int LB = serializer_pkg::LOCK_CNT_BITS;
  localparam int SB = serializer_pkg::LOSS_CNT_BITS;
  localparam int AB = serializer_pkg::ACT_CNT_BITS;
  localparam logic [LB-1:0] LOCK_LAST = LB'(LOCK_CYCLES - 1);
  localparam logic [SB-1:0] LOSS_LAST = SB'(LOSS_CYCLES - 1);

  // ---------------------------------------------------------------
  // Control side, on clk: power-down, clock detection, lock timer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    STANDBY,
    ACQUIRE,
    LOCKED
  } lock_state_e;

  typedef struct packed {
    lock_state_e fsm;
    logic [LB-1:0] lock_cnt;
    logic [SB-1:0] loss_cnt;
    logic act_prev;
    logic oe;
    logic locked;
  } ctrl_s;

  ctrl_s ctrl_reg;
  ctrl_s ctrl_next;
  logic pd_n_ctrl;
  logic act_ctrl;
  logic act_toggle;

  // Power-down pin is asynchronous to clk
  level_sync #(
    .WIDTH(1)
  ) pd_to_ctrl (
    .clk(clk),
    .async_in(power_down_n),
    .sync_out(pd_n_ctrl)
  );

  // Slow activity toggle from the strobe domain
  level_sync #(
    .WIDTH(1)
  ) act_to_ctrl (
    .clk(clk),
    .async_in(act_toggle),
    .sync_out(act_ctrl)
  );

  // Lock is a clean history of strobe activity; a gap that runs loss_cnt up to LOSS_LAST restarts it
  always_comb begin
    ctrl_next = ctrl_reg;
    ctrl_next.act_prev = act_ctrl;
    ctrl_next.oe = 1'b1;
    if (act_ctrl != ctrl_reg.act_prev) begin
      ctrl_next.loss_cnt = '0;
    end else if (ctrl_reg.loss_cnt != LOSS_LAST) begin
      ctrl_next.loss_cnt = ctrl_reg.loss_cnt + SB'(1);
    end
    case (ctrl_reg.fsm)
      STANDBY: begin
        ctrl_next.fsm = ACQUIRE;
        ctrl_next.lock_cnt = '0;
      end
      ACQUIRE: begin
        // Spread clocks keep toggling, only stopped ones count as lost
        if (ctrl_reg.loss_cnt == LOSS_LAST) begin
          ctrl_next.lock_cnt = '0;
        end else if (ctrl_reg.lock_cnt == LOCK_LAST) begin
          ctrl_next.fsm = LOCKED;
        end else begin
          ctrl_next.lock_cnt = ctrl_reg.lock_cnt + LB'(1);
        end
      end
      LOCKED: begin
        // Clock gone: fall back and relock on its return
        if (ctrl_reg.loss_cnt == LOSS_LAST) begin
          ctrl_next.fsm = ACQUIRE;
          ctrl_next.lock_cnt = '0;
        end
      end
      default: begin
        ctrl_next.fsm = STANDBY;
      end
    endcase
    ctrl_next.locked = (ctrl_next.fsm == LOCKED);
  end

  // Power-down reaches the enable in three edges, under the limit
  always_ff @(posedge clk) begin
    if (rst || !pd_n_ctrl) begin
      ctrl_reg.fsm <= STANDBY;
      ctrl_reg.lock_cnt <= '0;
      ctrl_reg.loss_cnt <= '0;
      ctrl_reg.act_prev <= 1'b0;
      ctrl_reg.oe <= 1'b0;
      ctrl_reg.locked <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign output_enable = ctrl_reg.oe;
  assign pll_locked = ctrl_reg.locked;

  // ---------------------------------------------------------------
  // Link side, on the falling edge of the shift clock
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [AB-1:0] act_cnt;
    logic [20:0] lane_pos;
    logic [20:0] lane_neg;
    logic [6:0] fclk_pos;
    logic [6:0] fclk_neg;
  } link_s;

  link_s link_reg;
  link_s link_next;
  logic strobe_clk;
  logic pd_n_link;
  logic locked_link;
  logic [20:0] word;

  // Falling edge of the input clock is the data strobe
  assign strobe_clk = ~shift_clock_in;

  level_sync #(
    .WIDTH(2)
  ) to_link (
    .clk(strobe_clk),
    .async_in({power_down_n, ctrl_reg.locked}),
    .sync_out({pd_n_link, locked_link})
  );

  // Lane l, slot s carries word bit 7*l+s: colour first, controls last
  assign word = {pixel_data_valid, frame_sync, line_sync, parallel_pixel_inputs};

  // Pairs sit low until lock so a receiver sees no garbage
  always_comb begin
    link_next = link_reg;
    link_next.act_cnt = link_reg.act_cnt + AB'(1);
    if (locked_link) begin
      link_next.lane_pos = word;
      link_next.lane_neg = ~word;
      link_next.fclk_pos = serializer_pkg::FWD_CLOCK_PATTERN;
      link_next.fclk_neg = ~serializer_pkg::FWD_CLOCK_PATTERN;
    end else begin
      link_next.lane_pos = serializer_pkg::LANE_IDLE;
      link_next.lane_neg = ~serializer_pkg::LANE_IDLE;
      link_next.fclk_pos = '0;
      link_next.fclk_neg = '1;
    end
  end

  // Reset only acts while the strobe runs; the enable covers the rest
  always_ff @(posedge strobe_clk) begin
    if (!pd_n_link) begin
      link_reg.act_cnt <= '0;
      link_reg.lane_pos <= serializer_pkg::LANE_IDLE;
      link_reg.lane_neg <= ~serializer_pkg::LANE_IDLE;
      link_reg.fclk_pos <= '0;
      link_reg.fclk_neg <= '1;
    end else begin
      link_reg <= link_next;
    end
  end

  // Top counter bit changes slowly enough for clk to sample safely
  assign act_toggle = link_reg.act_cnt[AB-1];
  assign serial_lane_pos = link_reg.lane_pos;
  assign serial_lane_neg = link_reg.lane_neg;
  assign forwarded_clock_pos = link_reg.fclk_pos;
  assign forwarded_clock_neg = link_reg.fclk_neg;
endmodule : parallel_rgb_to_lvds_serializer

//--- logic/serializer_pkg.sv
package serializer_pkg;
  // Link geometry
  localparam int LANES = 3;
  localparam int SLOTS = 7;
  localparam int PIXEL_BITS = 18;
  localparam int COLOUR_BITS = 6;
  localparam int WORD_BITS = LANES * SLOTS;
  // Slot pattern of the forwarded clock, bit k is slot k
  localparam logic [6:0] FWD_CLOCK_PATTERN = 7'h63;
  // Level of every slot while the pairs are pulled low
  localparam logic [20:0] LANE_IDLE = 21'h000000;
  // Timing, figures in their own unit, counts in cycles of clk
  localparam int CLK_PERIOD_PS = 25000;
  localparam int LOCK_TIME_MS = 10;
  // Scaled in ns first, a product in ps would overflow a 32-bit int
  localparam int LOCK_CYCLES = (LOCK_TIME_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  localparam int PD_DELAY_NS = 100;
  localparam int PD_DELAY_CYCLES = (PD_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam int LOSS_TIME_NS = 1000;
  localparam int LOSS_CYCLES = (LOSS_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int LOCK_CNT_BITS = 20;
  localparam int LOSS_CNT_BITS = 8;
  // Activity toggle is a bit of a free-running strobe counter
  localparam int ACT_CNT_BITS = 3;
endpackage : serializer_pkg

//--- sim/pixel_source.sv
`timescale 1ns/100ps
module pixel_source (
  input wire logic run,
  output logic shift_clock_in,
  output logic [17:0] parallel_pixel_inputs,
  output logic line_sync,
  output logic frame_sync,
  output logic pixel_data_valid
);
  logic [20:0] word_reg = 21'h000000;
  initial shift_clock_in = 1'b1;
  // 12 ns strobe, parked high between frames so no stray capture edge
  always begin
    #6;
    if (run || !shift_clock_in) shift_clock_in = ~shift_clock_in;
  end
  // Data moves on the rising edge, half a period clear of capture
  always @(posedge shift_clock_in) word_reg <= word_reg + 21'h0A5A5B;
  assign {pixel_data_valid, frame_sync, line_sync, parallel_pixel_inputs} = word_reg;
endmodule : pixel_source

//--- sim/serializer_props.sv
`timescale 1ns/100ps
module serializer_props #(
  parameter int LOCK_CYCLES = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic shift_clock_in,
  input wire logic [17:0] parallel_pixel_inputs,
  input wire logic line_sync,
  input wire logic frame_sync,
  input wire logic pixel_data_valid,
  input wire logic power_down_n,
  input wire logic [20:0] serial_lane_pos,
  input wire logic [20:0] serial_lane_neg,
  input wire logic [6:0] forwarded_clock_pos,
  input wire logic [6:0] forwarded_clock_neg,
  input wire logic output_enable,
  input wire logic pll_locked
);
  logic [20:0] word;
  logic [19:0] on_cnt_reg;
  assign word = {pixel_data_valid, frame_sync, line_sync, parallel_pixel_inputs};
  // Enabled time, so an early lock shows up
  always_ff @(posedge clk) begin
    on_cnt_reg <= (rst || !output_enable) ? 20'h00000 : on_cnt_reg + 20'h00001;
  end
  a_lane_legs: assert property (@(negedge shift_clock_in) disable iff (!power_down_n)
    serial_lane_neg == ~serial_lane_pos) else $error("lane legs");
  a_fclk_legs: assert property (@(negedge shift_clock_in) disable iff (!power_down_n)
    forwarded_clock_neg == ~forwarded_clock_pos) else $error("clock legs");
  a_word_order: assert property (@(negedge shift_clock_in) disable iff (!power_down_n)
    pll_locked [*4] |=> {serial_lane_pos, forwarded_clock_pos} == {$past(word), 7'h63})
    else $error("lane word");
  a_idle_unlocked: assert property (@(negedge shift_clock_in) disable iff (!power_down_n)
    !pll_locked [*5] |-> serial_lane_pos == 21'h000000 && forwarded_clock_pos == 7'h00)
    else $error("idle lanes");
  a_pd_delay: assert property (@(posedge clk) disable iff (rst)
    $fell(power_down_n) |-> ##[1:4] !output_enable) else $error("slow disable");
  a_pd_standby: assert property (@(posedge clk) disable iff (rst)
    !power_down_n [*4] |-> !output_enable && !pll_locked) else $error("standby");
  a_pd_release: assert property (@(posedge clk) disable iff (rst)
    $rose(power_down_n) |-> ##[1:4] output_enable) else $error("no enable");
  a_lock_time: assert property (@(posedge clk) disable iff (rst)
    $rose(pll_locked) |-> on_cnt_reg >= LOCK_CYCLES) else $error("early lock");
  c_data: cover property (@(negedge shift_clock_in) pll_locked [*5]);
  c_lock: cover property (@(posedge clk) $rose(pll_locked));
  c_pd: cover property (@(posedge clk) $fell(power_down_n));
endmodule : serializer_props

//--- sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b1;
  logic power_down_n = 1'b0;
  logic shift_clock_in, line_sync, frame_sync, pixel_data_valid, output_enable, pll_locked;
  logic [17:0] parallel_pixel_inputs;
  logic [20:0] serial_lane_pos, serial_lane_neg;
  logic [6:0] forwarded_clock_pos, forwarded_clock_neg;
  int errors = 0;
  int comparisons = 0;
  always #12.5 clk = ~clk;
  pixel_source u_pixel_source (.run, .shift_clock_in, .parallel_pixel_inputs, .line_sync,
    .frame_sync, .pixel_data_valid);
  parallel_rgb_to_lvds_serializer #(.LOCK_CYCLES(50)) u_parallel_rgb_to_lvds_serializer (
    .clk, .rst, .shift_clock_in, .parallel_pixel_inputs, .line_sync, .frame_sync,
    .pixel_data_valid, .power_down_n, .serial_lane_pos, .serial_lane_neg,
    .forwarded_clock_pos, .forwarded_clock_neg, .output_enable, .pll_locked);
  task automatic tally_and_finish();
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Bounded lock wait; running out closes the run
  task automatic wait_lock(output int n);
    n = 0;
    while (pll_locked !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 300) begin
        chk(21'h000000, 21'h000001);
        tally_and_finish();
      end
    end
  endtask : wait_lock
  task automatic t_data();
    logic [20:0] w;
    // Lock needs two strobe edges to reach the lanes and one more to land
    repeat (3) @(negedge shift_clock_in);
    repeat (4) begin
      @(negedge shift_clock_in);
      w = {pixel_data_valid, frame_sync, line_sync, parallel_pixel_inputs};
      #1;
      chk(serial_lane_pos, w);
      chk(serial_lane_neg, ~w);
      chk({14'h0000, forwarded_clock_pos}, 21'h000063);
    end
  endtask : t_data
  // Clock arrives only after release
  task automatic t_start();
    int n;
    @(posedge clk) run <= 1'b0;
    @(posedge clk) power_down_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk(output_enable, 1'b1);
    run <= 1'b1;
    wait_lock(n);
    chk(n > 0 && n <= 60, 1'b1);
    t_data();
  endtask : t_start
  task automatic t_restart();
    int n;
    @(posedge clk) run <= 1'b0;
    repeat (60) @(posedge clk);
    chk(pll_locked, 1'b0);
    run <= 1'b1;
    wait_lock(n);
    t_data();
  endtask : t_restart
  task automatic t_pd();
    int n;
    @(posedge clk) power_down_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk({output_enable, pll_locked}, 2'b00);
    power_down_n <= 1'b1;
    wait_lock(n);
    t_data();
  endtask : t_pd
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_start();
    t_restart();
    t_pd();
    tally_and_finish();
  end
endmodule : testbench
bind parallel_rgb_to_lvds_serializer serializer_props #(.LOCK_CYCLES(LOCK_CYCLES))
  u_serializer_props (.*);
